//--- design/lps_defines.vh
// Register map, field positions and timing constants of the line output and sequencer bank
`ifndef LPS_DEFINES_VH
`define LPS_DEFINES_VH

// ************************************
// Register indices and bus addressing
// ************************************
`define LPS_ADDR_W 12
`define LPS_IDX_LINEOUT 8'h5E
`define LPS_IDX_PUMP 8'h62
`define LPS_IDX_MODE 8'h68
`define LPS_IDX_SEQ0 8'h6C
`define LPS_IDX_STEP1 8'h6D
`define LPS_IDX_STEP2 8'h6E
`define LPS_IDX_SEQ3 8'h6F
`define LPS_IDX_STAT 8'h70

// ************************************
// Decoded register selects
// ************************************
`define LPS_SEL_NONE 4'h0
`define LPS_SEL_LINEOUT 4'h1
`define LPS_SEL_PUMP 4'h2
`define LPS_SEL_MODE 4'h3
`define LPS_SEL_SEQ0 4'h4
`define LPS_SEL_STEP1 4'h5
`define LPS_SEL_STEP2 4'h6
`define LPS_SEL_SEQ3 4'h7
`define LPS_SEL_STAT 4'h8

// ************************************
// Field positions
// ************************************
`define LPS_BIT_L_SHORT 7
`define LPS_BIT_L_FINAL 6
`define LPS_BIT_L_MIDDLE 5
`define LPS_BIT_L_INPUT 4
`define LPS_BIT_R_SHORT 3
`define LPS_BIT_R_FINAL 2
`define LPS_BIT_R_MIDDLE 1
`define LPS_BIT_R_INPUT 0
`define LPS_BIT_PUMP_ON 0
`define LPS_BIT_TRACKING 0
`define LPS_BIT_SEQ_ENA 8
`define LPS_BIT_GO 8
`define LPS_BIT_ABORT 9
`define LPS_BIT_LAST 14
`define LPS_RESET_16 16'h0000

// ************************************
// Sequencer memory and timing
// ************************************
`define LPS_RAM_DEPTH 32
`define LPS_STEP_W 28
`define LPS_STEP_UNIT_NS 62500
`define LPS_CLK_NS 5
`define LPS_WAIT_OFFSET 16'h0008
`define LPS_RESP_OKAY 2'b00
`define LPS_RESP_SLVERR 2'b10

`endif

//--- design/lps_step_ram.v
// Step memory of the write sequencer, registered read port
`timescale 1ns/1ps
`include "lps_defines.vh"
module lps_step_ram #(
   parameter DEPTH = `LPS_RAM_DEPTH,
   parameter WIDTH = `LPS_STEP_W,
   parameter AW = 5
) (
   input wire aclk,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [WIDTH-1:0] wdata,
   input wire [AW-1:0] raddr,
   output reg [WIDTH-1:0] rdata
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];

   always @(posedge aclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule // lps_step_ram

//--- design/lps_regs.v
// Line output, charge pump and write sequencer register bank on AXI4-Lite
// Contract
// - Each line output stays shorted until its short-release bit (7 left, 3 right) is 1.
// - Final drive stage follows its bit: 6 left, 2 right.
// - Intermediate stage follows its bit: 5 left, 1 right.
// - Input stage follows its bit: 4 left, 0 right.
// - Bit 0 selects pump supply from volume settings (0) or live level (1).
// - Writes to step registers are copied into memory at the 5-bit write index.
// - Write index values 0 to 31 address only writable step memory.
// - Start runs steps from start index until a last step, then clears itself.
// - Each step takes 62.5us times (two to the wait code plus 8).
// - Abort ends the running sequence at once and returns control to software.
// - Each step writes a 1 to 8 bit field at lsb position 0 to 15.
`timescale 1ns/1ps
`include "lps_defines.vh"
module lps_regs #(
   parameter [15:0] STEP_UNIT_CYCLES = `LPS_STEP_UNIT_NS / `LPS_CLK_NS
) (
   input wire aclk,
   input wire aresetn,
   input wire [`LPS_ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [`LPS_ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output wire left_line_short_release,
   output wire left_line_final_stage_on,
   output wire left_line_middle_stage_on,
   output wire left_line_input_stage_on,
   output wire right_line_short_release,
   output wire right_line_final_stage_on,
   output wire right_line_middle_stage_on,
   output wire right_line_input_stage_on,
   output wire pump_enable,
   output wire pump_level_tracking,
   output wire sequencer_busy
);
   // ************************************
   // State codes
   // ************************************
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_FETCH = 2'b01;
   localparam [1:0] ST_EXEC = 2'b10;
   localparam [1:0] ST_WAIT = 2'b11;

   // ************************************
   // Helper functions
   // ************************************
   function [3:0] decode;
      input [`LPS_ADDR_W-1:0] a;
      begin
         if (a == {2'b00, `LPS_IDX_LINEOUT, 2'b00}) decode = `LPS_SEL_LINEOUT;
         else if (a == {2'b00, `LPS_IDX_PUMP, 2'b00}) decode = `LPS_SEL_PUMP;
         else if (a == {2'b00, `LPS_IDX_MODE, 2'b00}) decode = `LPS_SEL_MODE;
         else if (a == {2'b00, `LPS_IDX_SEQ0, 2'b00}) decode = `LPS_SEL_SEQ0;
         else if (a == {2'b00, `LPS_IDX_STEP1, 2'b00}) decode = `LPS_SEL_STEP1;
         else if (a == {2'b00, `LPS_IDX_STEP2, 2'b00}) decode = `LPS_SEL_STEP2;
         else if (a == {2'b00, `LPS_IDX_SEQ3, 2'b00}) decode = `LPS_SEL_SEQ3;
         else if (a == {2'b00, `LPS_IDX_STAT, 2'b00}) decode = `LPS_SEL_STAT;
         else decode = `LPS_SEL_NONE;
      end
   endfunction

   // Byte lanes 0 and 1 only; upper lanes have no storage
   function [15:0] merge;
      input [15:0] old;
      input [31:0] d;
      input [3:0] strb;
      begin
         merge = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
      end
   endfunction

   // Insert a 1 to 8 bit field; bits beyond bit 15 fall off
   function [15:0] insert;
      input [15:0] old;
      input [7:0] d;
      input [3:0] lsb;
      input [2:0] wcode;
      reg [15:0] mask;
      begin
         mask = ((16'h0002 << wcode) - 16'h0001) << lsb;
         insert = (old & ~mask) | (({8'h00, d} << lsb) & mask);
      end
   endfunction

   // ************************************
   // Storage
   // ************************************
   reg [7:0] line_stage;
   reg pump_on;
   reg tracking;
   reg seq_ena;
   reg [4:0] step_write_index;
   reg [14:0] step1;
   reg [14:0] step2;
   reg [5:0] start_index;
   reg sequencer_go;
   reg [5:0] cur_index;
   reg [1:0] state;
   reg [15:0] unit_cnt;
   reg [15:0] mult_cnt;
   reg [15:0] mult_target;
   reg ram_we;
   reg [`LPS_ADDR_W-1:0] aw_addr;
   reg aw_full;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_full;
   wire [`LPS_STEP_W-1:0] step_word;
   wire [3:0] wr_sel;
   wire [3:0] rd_sel;
   wire wr_fire;
   wire rd_fire;
   wire [15:0] wd_line;
   wire [15:0] wd_pump;
   wire [15:0] wd_mode;
   wire [15:0] wd_seq0;
   wire [15:0] wd_step1;
   wire [15:0] wd_step2;
   wire [15:0] wd_seq3;
   wire [15:0] seq_line;
   wire [15:0] seq_pump;
   wire [15:0] seq_mode;
   wire [7:0] ex_data;
   wire [7:0] ex_addr;
   wire [3:0] ex_lsb;
   wire [2:0] ex_width;
   wire [3:0] ex_wait;
   wire ex_last;
   wire unit_done;
   reg [31:0] next_rdata;

   // ************************************
   // Outputs
   // ************************************
   assign left_line_short_release = line_stage[`LPS_BIT_L_SHORT];
   assign left_line_final_stage_on = line_stage[`LPS_BIT_L_FINAL];
   assign left_line_middle_stage_on = line_stage[`LPS_BIT_L_MIDDLE];
   assign left_line_input_stage_on = line_stage[`LPS_BIT_L_INPUT];
   assign right_line_short_release = line_stage[`LPS_BIT_R_SHORT];
   assign right_line_final_stage_on = line_stage[`LPS_BIT_R_FINAL];
   assign right_line_middle_stage_on = line_stage[`LPS_BIT_R_MIDDLE];
   assign right_line_input_stage_on = line_stage[`LPS_BIT_R_INPUT];
   assign pump_enable = pump_on;
   assign pump_level_tracking = tracking;
   assign sequencer_busy = (state != ST_IDLE);

   // ************************************
   // AXI4-Lite handshakes
   // ************************************
   assign s_axi_awready = ~aw_full;
   assign s_axi_wready = ~w_full;
   assign wr_fire = aw_full & w_full & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_fire = s_axi_arvalid & ~s_axi_rvalid;
   assign wr_sel = decode(aw_addr);
   assign rd_sel = decode(s_axi_araddr);

   assign wd_line = merge({8'h00, line_stage}, w_data, w_strb);
   assign wd_pump = merge({15'h0000, pump_on}, w_data, w_strb);
   assign wd_mode = merge({15'h0000, tracking}, w_data, w_strb);
   assign wd_seq0 = merge({7'h00, seq_ena, 3'h0, step_write_index}, w_data, w_strb);
   assign wd_step1 = merge({1'b0, step1}, w_data, w_strb);
   assign wd_step2 = merge({1'b0, step2}, w_data, w_strb);
   assign wd_seq3 = merge({7'h00, sequencer_go, 2'b00, start_index}, w_data, w_strb);

   // ************************************
   // Step memory
   // ************************************
   // Step word: last, wait code, width, lsb, target index, data
   lps_step_ram #(
      .DEPTH(`LPS_RAM_DEPTH),
      .WIDTH(`LPS_STEP_W),
      .AW(5)
   ) u_ram (
      .aclk(aclk),
      .we(ram_we),
      .waddr(step_write_index),
      .wdata({step2[14], step2[11:8], step1[14:12], step1[11:8], step1[7:0], step2[7:0]}),
      .raddr(cur_index[4:0]),
      .rdata(step_word)
   );

   assign ex_last = step_word[27];
   assign ex_wait = step_word[26:23];
   assign ex_width = step_word[22:20];
   assign ex_lsb = step_word[19:16];
   assign ex_addr = step_word[15:8];
   assign ex_data = step_word[7:0];
   assign seq_line = insert({8'h00, line_stage}, ex_data, ex_lsb, ex_width);
   assign seq_pump = insert({15'h0000, pump_on}, ex_data, ex_lsb, ex_width);
   assign seq_mode = insert({15'h0000, tracking}, ex_data, ex_lsb, ex_width);
   assign unit_done = (unit_cnt == STEP_UNIT_CYCLES - 16'h0001);

   // ************************************
   // Register file and sequencer
   // ************************************
   always @(posedge aclk) begin
      if (!aresetn) begin
         line_stage <= 8'h00;
         pump_on <= 1'b0;
         tracking <= 1'b0;
         seq_ena <= 1'b0;
         step_write_index <= 5'h00;
         step1 <= 15'h0000;
         step2 <= 15'h0000;
         start_index <= 6'h00;
         sequencer_go <= 1'b0;
         cur_index <= 6'h00;
         state <= ST_IDLE;
         unit_cnt <= 16'h0000;
         mult_cnt <= 16'h0000;
         mult_target <= 16'h0000;
         ram_we <= 1'b0;
         aw_addr <= {`LPS_ADDR_W{1'b0}};
         aw_full <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         w_full <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `LPS_RESP_OKAY;
      end else begin
         // Address and data are caught independently, in either order
         if (s_axi_awvalid && !aw_full) begin
            aw_addr <= s_axi_awaddr;
            aw_full <= 1'b1;
         end
         if (s_axi_wvalid && !w_full) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_full <= 1'b1;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         ram_we <= 1'b0;

         // Sequencer; its writes come before bus writes, so software wins a tie
         case (state)
            ST_IDLE: begin
               unit_cnt <= 16'h0000;
               mult_cnt <= 16'h0000;
               if (sequencer_go && seq_ena) begin
                  cur_index <= start_index;
                  state <= ST_FETCH;
               end else begin
                  sequencer_go <= 1'b0;
               end
            end
            ST_FETCH: begin
               // Only writable steps exist; anything above ends the run
               if (cur_index[5]) begin
                  sequencer_go <= 1'b0;
                  state <= ST_IDLE;
               end else begin
                  state <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               if (ex_addr == `LPS_IDX_LINEOUT) line_stage <= seq_line[7:0];
               if (ex_addr == `LPS_IDX_PUMP) pump_on <= seq_pump[0];
               if (ex_addr == `LPS_IDX_MODE) tracking <= seq_mode[0];
               mult_target <= (16'h0001 << ex_wait) + `LPS_WAIT_OFFSET;
               unit_cnt <= 16'h0001;
               mult_cnt <= 16'h0000;
               state <= ST_WAIT;
            end
            ST_WAIT: begin
               // Exec cycle counts toward the step time
               if (unit_done) begin
                  unit_cnt <= 16'h0000;
                  if (mult_cnt == mult_target - 16'h0001) begin
                     if (ex_last) begin
                        sequencer_go <= 1'b0;
                        state <= ST_IDLE;
                     end else begin
                        cur_index <= cur_index + 6'h01;
                        state <= ST_FETCH;
                     end
                  end else begin
                     mult_cnt <= mult_cnt + 16'h0001;
                  end
               end else begin
                  unit_cnt <= unit_cnt + 16'h0001;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase

         // Dropping the enable mid-run stops like an abort
         if (state != ST_IDLE && !seq_ena) begin
            sequencer_go <= 1'b0;
            state <= ST_IDLE;
         end

         // Bus write
         if (wr_fire) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `LPS_RESP_OKAY;
            case (wr_sel)
               `LPS_SEL_LINEOUT: line_stage <= wd_line[7:0];
               `LPS_SEL_PUMP: pump_on <= wd_pump[`LPS_BIT_PUMP_ON];
               `LPS_SEL_MODE: tracking <= wd_mode[`LPS_BIT_TRACKING];
               `LPS_SEL_SEQ0: begin
                  seq_ena <= wd_seq0[`LPS_BIT_SEQ_ENA];
                  step_write_index <= wd_seq0[4:0];
               end
               `LPS_SEL_STEP1: begin
                  step1 <= {wd_step1[14:12], wd_step1[11:8], wd_step1[7:0]};
                  ram_we <= 1'b1;
               end
               `LPS_SEL_STEP2: begin
                  step2 <= {wd_step2[14], 2'b00, wd_step2[11:8], wd_step2[7:0]};
                  ram_we <= 1'b1;
               end
               `LPS_SEL_SEQ3: begin
                  start_index <= wd_seq3[5:0];
                  if (wd_seq3[`LPS_BIT_ABORT]) begin
                     sequencer_go <= 1'b0;
                     state <= ST_IDLE;
                  end else if (wd_seq3[`LPS_BIT_GO] && seq_ena) begin
                     sequencer_go <= 1'b1;
                  end
               end
               `LPS_SEL_STAT: s_axi_bresp <= `LPS_RESP_OKAY;
               default: s_axi_bresp <= `LPS_RESP_SLVERR;
            endcase
         end
      end
   end

   // ************************************
   // Read path
   // ************************************
   always @* begin
      next_rdata = 32'h00000000;
      case (rd_sel)
         `LPS_SEL_LINEOUT: next_rdata[7:0] = line_stage;
         `LPS_SEL_PUMP: next_rdata[`LPS_BIT_PUMP_ON] = pump_on;
         `LPS_SEL_MODE: next_rdata[`LPS_BIT_TRACKING] = tracking;
         `LPS_SEL_SEQ0: next_rdata[15:0] = {7'h00, seq_ena, 3'h0, step_write_index};
         `LPS_SEL_STEP1: next_rdata[14:0] = step1;
         `LPS_SEL_STEP2: next_rdata[14:0] = step2;
         `LPS_SEL_SEQ3: next_rdata[15:0] = {7'h00, sequencer_go, 2'b00, start_index};
         `LPS_SEL_STAT: next_rdata[15:0] = {6'h00, cur_index, 3'h0, sequencer_busy};
         default: next_rdata = 32'h00000000;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `LPS_RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= (rd_sel == `LPS_SEL_NONE) ? `LPS_RESP_SLVERR : `LPS_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // lps_regs

//--- dv/lps_regs_checker.sv
// Assertions on the ports of the line output and sequencer register bank
`timescale 1ns/1ps
`include "lps_defines.vh"
module lps_regs_checker #(
   parameter [15:0] STEP_UNIT_CYCLES = `LPS_STEP_UNIT_NS / `LPS_CLK_NS
) (
   input wire aclk,
   input wire aresetn,
   input wire [`LPS_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire left_line_short_release,
   input wire left_line_final_stage_on,
   input wire left_line_middle_stage_on,
   input wire left_line_input_stage_on,
   input wire right_line_short_release,
   input wire right_line_final_stage_on,
   input wire right_line_middle_stage_on,
   input wire right_line_input_stage_on,
   input wire pump_enable,
   input wire pump_level_tracking,
   input wire sequencer_busy
);
   // ****
   // Capture of the write that fires
   // ****
   logic [`LPS_ADDR_W-1:0] c_addr;
   logic [15:0] c_data;
   logic [3:0] c_strb;
   logic bv_q;
   logic seq_en;
   wire fire = s_axi_bvalid && !bv_q;
   wire [7:0] line = {left_line_short_release, left_line_final_stage_on,
      left_line_middle_stage_on, left_line_input_stage_on, right_line_short_release,
      right_line_final_stage_on, right_line_middle_stage_on, right_line_input_stage_on};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         c_addr <= '0;
         c_data <= 16'h0000;
         c_strb <= 4'h0;
         bv_q <= 1'b0;
         seq_en <= 1'b0;
      end else begin
         bv_q <= s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) c_addr <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) c_data <= s_axi_wdata[15:0];
         if (s_axi_wvalid && s_axi_wready) c_strb <= s_axi_wstrb;
         if (fire && c_addr == 12'h1B0 && c_strb[1]) seq_en <= c_data[8];
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_line_wr; fire && c_addr == 12'h178 && c_strb[0]; endsequence
   sequence s_mode_wr; fire && c_addr == 12'h1A0 && c_strb[0]; endsequence
   sequence s_ctl_wr; fire && c_addr == 12'h1BC && c_strb[1]; endsequence
   // ****
   // Properties
   // ****
   property p_short; s_line_wr |-> line[7] == c_data[7] && line[3] == c_data[3]; endproperty
   a_short: assert property (p_short) else $error("short release bits wrong");
   property p_final; s_line_wr |-> line[6] == c_data[6] && line[2] == c_data[2]; endproperty
   a_final: assert property (p_final) else $error("final stage bits wrong");
   property p_middle; s_line_wr |-> line[5] == c_data[5] && line[1] == c_data[1]; endproperty
   a_middle: assert property (p_middle) else $error("middle stage bits wrong");
   property p_input; s_line_wr |-> line[4] == c_data[4] && line[0] == c_data[0]; endproperty
   a_input: assert property (p_input) else $error("input stage bits wrong");
   property p_track; s_mode_wr |-> pump_level_tracking == c_data[0]; endproperty
   a_track: assert property (p_track) else $error("tracking mode wrong");
   property p_idle; !seq_en |-> !sequencer_busy; endproperty
   a_idle: assert property (p_idle) else $error("busy while disabled");
   property p_go;
      s_ctl_wr ##0 (seq_en && c_data[8] && !c_data[9] && !c_data[5] && !sequencer_busy)
         |=> sequencer_busy;
   endproperty
   a_go: assert property (p_go) else $error("start did not run");
   property p_abort; s_ctl_wr ##0 c_data[9] |=> !sequencer_busy; endproperty
   a_abort: assert property (p_abort) else $error("abort did not stop");
   property p_reset;
      disable iff (1'b0) !aresetn |=> line == 8'h00 && !pump_enable
         && !pump_level_tracking && !sequencer_busy;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not cleared");
endmodule // lps_regs_checker

bind lps_regs lps_regs_checker #(.STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)) u_chk (.*);

//--- dv/lps_host.sv
// Host software model: AXI4-Lite master and line output power-up order
`timescale 1ns/1ps
module lps_host (
   input wire aclk,
   output logic [11:0] s_axi_awaddr,
   output logic [2:0] s_axi_awprot,
   output logic s_axi_awvalid,
   input wire s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   output logic s_axi_bready,
   output logic [11:0] s_axi_araddr,
   output logic [2:0] s_axi_arprot,
   output logic s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   output logic s_axi_rready,
   output logic hung
);
   localparam int LIM = 50;
   localparam int SETTLE = 4000; // 20us at a 5 ns clock
   initial begin
      {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot} = '0;
      {s_axi_arvalid, s_axi_rready, hung} = '0;
   end
   task automatic wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] r);
      int n;
      logic ta, tw, tb;
      n = 0;
      tb = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wstrb <= 4'h3;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!tb && n < LIM) begin
         #1;
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         n++;
         // Released lines show a changed value, not the stale one
         if (ta) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
         if (tw) {s_axi_wvalid, s_axi_wdata} <= {1'b0, 16'hFFFF, ~d};
      end
      s_axi_bready <= 1'b0;
      if (!tb) hung = 1'b1;
      #1;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ta, tr;
      n = 0;
      tr = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!tr && n < LIM) begin
         #1;
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         n++;
         if (ta) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~a};
      end
      s_axi_rready <= 1'b0;
      if (!tr) hung = 1'b1;
      #1;
   endtask
   // Offset cancellation is outside this block, so its slot is empty
   task automatic power_up(input int sh, input logic [7:0] base);
      logic [1:0] r;
      wr(12'h178, {8'h00, base | (8'h01 << sh)}, r);
      repeat (SETTLE) @(posedge aclk);
      wr(12'h178, {8'h00, base | (8'h03 << sh)}, r);
      wr(12'h178, {8'h00, base | (8'h07 << sh)}, r);
      wr(12'h178, {8'h00, base | (8'h0F << sh)}, r);
   endtask
endmodule // lps_host

//--- dv/testbench.sv
// Self-checking testbench of the line output and sequencer register bank
`timescale 1ns/1ps
`include "lps_defines.vh"
module testbench;
   localparam logic [15:0] UNIT = 16'h0002; // Short step unit keeps runs brief
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   wire [`LPS_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   wire [2:0] s_axi_awprot, s_axi_arprot;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0] s_axi_wstrb;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hung;
   wire left_line_short_release, left_line_final_stage_on, left_line_middle_stage_on;
   wire left_line_input_stage_on, right_line_short_release, right_line_final_stage_on;
   wire right_line_middle_stage_on, right_line_input_stage_on;
   wire pump_enable, pump_level_tracking, sequencer_busy;
   wire [7:0] line = {left_line_short_release, left_line_final_stage_on,
      left_line_middle_stage_on, left_line_input_stage_on, right_line_short_release,
      right_line_final_stage_on, right_line_middle_stage_on, right_line_input_stage_on};
   int error_cnt = 0;
   int total_checks = 0;
   logic [31:0] rdv;
   logic [1:0] rsp;
   always #2.5 aclk = ~aclk;
   lps_regs #(.STEP_UNIT_CYCLES(UNIT)) DUT (.*);
   lps_host u_host (.*);
   always @(posedge hung) end_sim();
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      u_host.rd(a, rdv, rsp);
      check("read data", rdv, exp);
      check("read resp", {30'h0, rsp}, {30'h0, er});
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      u_host.wr(a, d, rsp);
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_reset();
      #1;
      check("outputs", {line, pump_enable, pump_level_tracking, sequencer_busy}, 0);
      rchk(12'h178, 0, `LPS_RESP_OKAY);
      rchk(12'h188, 0, `LPS_RESP_OKAY);
      rchk(12'h1A0, 0, `LPS_RESP_OKAY);
      rchk(12'h1B0, 0, `LPS_RESP_OKAY);
   endtask
   task automatic t_line();
      u_host.power_up(4, 8'h00);
      check("left up", {24'h0, line}, 32'h000000F0);
      u_host.power_up(0, 8'hF0);
      check("both up", {24'h0, line}, 32'h000000FF);
      for (int i = 0; i < 8; i++) begin
         wr(12'h178, 16'h0001 << i);
         check("line bit", {24'h0, line}, 32'h1 << i);
         rchk(12'h178, 32'h1 << i, `LPS_RESP_OKAY);
      end
   endtask
   task automatic t_pump();
      wr(12'h188, 16'hFFFF);
      check("pump", {31'h0, pump_enable}, 1);
      rchk(12'h188, 32'h00000001, `LPS_RESP_OKAY);
      wr(12'h1A0, 16'h0001);
      check("tracking", {31'h0, pump_level_tracking}, 1);
      wr(12'h1A0, 16'h0000);
      check("volume mode", {31'h0, pump_level_tracking}, 0);
      wr(12'h100, 16'h00FF);
      check("unmapped wr", {30'h0, rsp}, {30'h0, `LPS_RESP_SLVERR});
      rchk(12'h100, 0, `LPS_RESP_SLVERR);
   endtask
   task automatic t_seq_run();
      int n;
      n = 0;
      wr(12'h178, 16'h0003);
      wr(12'h1B0, 16'h011F);
      wr(12'h1B4, 16'h345E);
      wr(12'h1B8, 16'h40A5);
      wr(12'h1BC, 16'h011F);
      while (sequencer_busy && n < 200) begin
         @(posedge aclk);
         #1;
         n++;
      end
      // Wait code 0 gives nine units of step time, plus fetch slack
      check("step time", {31'h0, n >= 18 && n <= 21}, 1);
      check("field write", {24'h0, line}, 32'h00000053);
      rchk(12'h1BC, 32'h0000001F, `LPS_RESP_OKAY);
   endtask
   task automatic t_abort();
      wr(12'h1B8, 16'h0300);
      wr(12'h1BC, 16'h011F);
      repeat (5) @(posedge aclk);
      #1;
      check("running", {31'h0, sequencer_busy}, 1);
      wr(12'h1BC, 16'h0200);
      check("aborted", {31'h0, sequencer_busy}, 0);
      rchk(12'h1BC, 0, `LPS_RESP_OKAY);
   endtask
   task automatic t_seq_off();
      wr(12'h1B0, 16'h0000);
      wr(12'h1BC, 16'h0100);
      repeat (3) @(posedge aclk);
      #1;
      check("disabled", {31'h0, sequencer_busy}, 0);
      rchk(12'h1BC, 0, `LPS_RESP_OKAY);
   endtask
   task automatic end_sim();
      if (hung) error_cnt++;
      $display("Checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_line();
      t_pump();
      t_seq_run();
      t_abort();
      t_seq_off();
      end_sim();
   end
endmodule // testbench
